/* iorm_core_map.sv */
// Purpose: I/O port decode, vector table, stack pointers and data RAM partition of the core.
// Assumes: The core presents one I/O instruction per cycle and reads the answer one cycle later.
// Notes: Behaviour behind each port register other than the timer and the watchdog clear lives in the peripheral blocks fed by regs_q.

////////////////////////////////////////////////////////////////////////////////
// How it works
// - After reset the fetch address is zero.
// - Bus reset, 128 us and 1.024 ms timer vectors at 0x0002, 0x0004, 0x0006.
// - Endpoint 0, 1, 2 vectors at 0x0008, 0x000A, 0x000C.
// - Current sink vector 0x0014, GPIO 0x0016; other low slots carry no vector.
// - Data RAM holds exactly 256 bytes with an 8-bit address.
// - Program stack starts at zero and grows upward.
// - Data stack grows downward from a firmware chosen start.
// - Endpoint 2, 1, 0 buffers start at 0xE8, 0xF0, 0xF8.
// - A port read returns the selected port into the accumulator.
// - A port write stores the accumulator into the selected port.
// - Indexed write targets the address field plus the index register.
// - Indexed write with zero address field selects purely by index.
// - Timer low byte readable at 0x24.
// - Reading the low byte latches the timer's upper four bits at 0x25.
// - Four write-only port interrupt enables at 0x04 to 0x07.
// - Any write to 0x26 is a watchdog clear strobe.
// - Addresses 0x38 to 0x3F hold one four-bit sink level per pin.
// - Endpoint 1 and 2 mode registers are read/clear; endpoint 0 is read/write.
// - Data stack pointer resets to zero; first push lands at 0xFF.
// - Status register at 0xFF records power-on, bus and watchdog resets.
module iorm_core_map #(
  parameter bit ROM_8K = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input iorm_pkg::iorm_io_req_t io_req,
  output logic [7:0] io_rdata_q,
  output logic io_rvalid_q,
  input wire logic irq_take,
  input iorm_pkg::iorm_src_t irq_src,
  output logic [13:0] vector_q,
  output logic vector_valid_q,
  input wire logic [13:0] prog_addr,
  output logic prog_addr_ok,
  input iorm_pkg::iorm_stack_op_t stack_op,
  output logic [7:0] psp_q,
  output logic [7:0] dsp_q,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  output logic [7:0] ram_rdata,
  output iorm_pkg::iorm_region_t ram_region,
  input wire logic usb_bus_reset_seen,
  input wire logic watchdog_reset_seen,
  input wire logic [1:0][7:0] ep_mode_hw_set,
  output logic watchdog_clear_q,
  output iorm_pkg::iorm_regs_t regs_q
);
  import iorm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Maps an interrupt source onto its vector table slot.
  function automatic logic [13:0] vector_of(input iorm_src_t src);
    case (src)
      IORM_SRC_USB_RESET: vector_of = VEC_USB_RESET;
      IORM_SRC_TMR_128US: vector_of = VEC_TMR_128US;
      IORM_SRC_TMR_1MS: vector_of = VEC_TMR_1MS;
      IORM_SRC_EP0: vector_of = VEC_EP0;
      IORM_SRC_EP1: vector_of = VEC_EP1;
      IORM_SRC_EP2: vector_of = VEC_EP2;
      IORM_SRC_SINK: vector_of = VEC_CURRENT_SINK;
      IORM_SRC_GPIO: vector_of = VEC_GPIO;
      default: vector_of = VEC_RESET;
    endcase
  endfunction

  // Names the RAM partition an address falls in.
  function automatic iorm_region_t region_of(input logic [7:0] a);
    if (a >= EP0_BUF_BASE) begin
      region_of = IORM_RGN_EP0;
    end else if (a >= EP1_BUF_BASE) begin
      region_of = IORM_RGN_EP1;
    end else if (a >= EP2_BUF_BASE) begin
      region_of = IORM_RGN_EP2;
    end else begin
      region_of = IORM_RGN_GENERAL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address formation and strobes.
  logic [7:0] wr_addr;
  logic wr_any;
  logic rd_hit_timer_low;
  logic [TIMER_WIDTH-1:0] timer_count;
  logic [3:0] timer_high_q;

  // An indexed write adds X; a zero field leaves X alone as the address.
  assign wr_addr = io_req.port_indexed_write_instr ? 8'(io_req.addr + io_req.index_x)
                                                   : io_req.addr;
  assign wr_any = io_req.port_write_instr | io_req.port_indexed_write_instr;
  assign rd_hit_timer_low = io_req.port_read_instr && io_req.addr == A_TIMER_LOW;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.
  iorm_free_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .count_q(timer_count)
  );

  iorm_data_ram u_ram (
    .mclk(mclk),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .we(ram_we),
    .rdata(ram_rdata)
  );

  assign ram_region = region_of(ram_addr);

  // Program memory bound depends on the variant; the top 32 bytes of 8 KB stay unused.
  assign prog_addr_ok = prog_addr <= (ROM_8K ? ROM_END_8K : ROM_END_6K);

  ////////////////////////////////////////////////////////////////////////////
  // Vector register: zero after reset, table slot on each taken interrupt.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vector_q <= VEC_RESET;
      vector_valid_q <= 1'b1;
    end else if (irq_take) begin
      vector_q <= vector_of(irq_src);
      vector_valid_q <= 1'b1;
    end else begin
      vector_valid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program stack grows upward from zero.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      psp_q <= PSP_RESET;
    end else if (stack_op.psp_push) begin
      psp_q <= psp_q + 8'h01;
    end else if (stack_op.psp_pop) begin
      psp_q <= psp_q - 8'h01;
    end
  end

  // Data stack pre-decrements on push, so a push from zero wraps to the top byte.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dsp_q <= DSP_RESET;
    end else if (stack_op.dsp_load) begin
      dsp_q <= stack_op.dsp_value;
    end else if (stack_op.dsp_push) begin
      dsp_q <= dsp_q - 8'h01;
    end else if (stack_op.dsp_pop) begin
      dsp_q <= dsp_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port and GPIO configuration registers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regs_q.port_data <= '0;
      regs_q.port_irq_en <= '0;
      regs_q.pin_drive_cfg <= REG_RESET;
    end else if (wr_any) begin
      if (wr_addr <= A_PORT3_DATA) begin
        regs_q.port_data[wr_addr[1:0]] <= io_req.acc;
      end else if (wr_addr >= A_PORT0_IRQ_EN && wr_addr <= A_PORT3_IRQ_EN) begin
        regs_q.port_irq_en[wr_addr[1:0]] <= io_req.acc;
      end else if (wr_addr == A_PIN_DRIVE_CFG) begin
        regs_q.pin_drive_cfg <= io_req.acc;
      end
    end
  end

  // USB address, endpoint counters and interrupt enables.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regs_q.usb_dev_addr <= REG_RESET;
      regs_q.ep_count <= '0;
      regs_q.usb_stat_ctrl <= REG_RESET;
      regs_q.global_irq_en <= REG_RESET;
      regs_q.ep_irq_en <= REG_RESET;
    end else if (wr_any) begin
      case (wr_addr)
        A_USB_DEV_ADDR: regs_q.usb_dev_addr <= io_req.acc;
        A_EP0_COUNT: regs_q.ep_count[0] <= io_req.acc;
        A_EP1_COUNT: regs_q.ep_count[1] <= io_req.acc;
        A_EP2_COUNT: regs_q.ep_count[2] <= io_req.acc;
        A_USB_STAT_CTRL: regs_q.usb_stat_ctrl <= io_req.acc;
        A_GLOBAL_IRQ_EN: regs_q.global_irq_en <= io_req.acc;
        A_EP_IRQ_EN: regs_q.ep_irq_en <= io_req.acc;
        default: regs_q.usb_dev_addr <= regs_q.usb_dev_addr;
      endcase
    end
  end

  // Endpoint 0 mode is plain read/write.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regs_q.ep_mode[0] <= REG_RESET;
    end else if (wr_any && wr_addr == A_EP0_MODE) begin
      regs_q.ep_mode[0] <= io_req.acc;
    end
  end

  // Endpoint 1 and 2 modes are read/clear: a write can only drop bits, and a hardware set wins.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regs_q.ep_mode[2:1] <= '0;
    end else begin
      regs_q.ep_mode[1] <= ((wr_any && wr_addr == A_EP1_MODE) ? (regs_q.ep_mode[1] & io_req.acc)
                                                               : regs_q.ep_mode[1]) | ep_mode_hw_set[0];
      regs_q.ep_mode[2] <= ((wr_any && wr_addr == A_EP2_MODE) ? (regs_q.ep_mode[2] & io_req.acc)
                                                               : regs_q.ep_mode[2]) | ep_mode_hw_set[1];
    end
  end

  // Current sink port data, interrupt enable, polarity and per-pin levels.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regs_q.sink_data <= REG_RESET;
      regs_q.sink_irq_en <= REG_RESET;
      regs_q.sink_irq_pol <= REG_RESET;
      regs_q.sink_level <= '0;
    end else if (wr_any) begin
      if (wr_addr == A_SINK_DATA) begin
        regs_q.sink_data <= io_req.acc;
      end else if (wr_addr == A_SINK_IRQ_EN) begin
        regs_q.sink_irq_en <= io_req.acc;
      end else if (wr_addr == A_SINK_IRQ_POL) begin
        regs_q.sink_irq_pol <= io_req.acc;
      end else if (wr_addr >= A_SINK_LEVEL0 && wr_addr <= A_SINK_LEVEL7) begin
        regs_q.sink_level[wr_addr[2:0]] <= io_req.acc[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor status: reset starts with the power-on flag; cause flags set over a clear.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regs_q.proc_stat_ctrl <= PSC_RESET;
    end else begin
      regs_q.proc_stat_ctrl <= (wr_any && wr_addr == A_PROC_STAT_CTRL) ? io_req.acc : regs_q.proc_stat_ctrl;
      if (usb_bus_reset_seen) begin
        regs_q.proc_stat_ctrl[PSC_USB_RST_BIT] <= 1'b1;
      end
      if (watchdog_reset_seen) begin
        regs_q.proc_stat_ctrl[PSC_WDR_BIT] <= 1'b1;
      end
    end
  end

  // Watchdog clear is a one-cycle strobe; the written value is discarded.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      watchdog_clear_q <= 1'b0;
    end else begin
      watchdog_clear_q <= wr_any && wr_addr == A_WDT_CLEAR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer upper bits frozen by a low-byte read so the two bytes belong together.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_high_q <= 4'h0;
    end else if (rd_hit_timer_low) begin
      timer_high_q <= timer_count[11:8];
    end
  end

  // Read return register; write-only and unassigned ports answer zero.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_rdata_q <= 8'h00;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= io_req.port_read_instr;
      if (io_req.port_read_instr) begin
        case (io_req.addr)
          8'h00, 8'h01, 8'h02, A_PORT3_DATA: io_rdata_q <= regs_q.port_data[io_req.addr[1:0]];
          A_PIN_DRIVE_CFG: io_rdata_q <= regs_q.pin_drive_cfg;
          A_USB_DEV_ADDR: io_rdata_q <= regs_q.usb_dev_addr;
          A_EP0_COUNT: io_rdata_q <= regs_q.ep_count[0];
          A_EP0_MODE: io_rdata_q <= regs_q.ep_mode[0];
          A_EP1_COUNT: io_rdata_q <= regs_q.ep_count[1];
          A_EP1_MODE: io_rdata_q <= regs_q.ep_mode[1];
          A_EP2_COUNT: io_rdata_q <= regs_q.ep_count[2];
          A_EP2_MODE: io_rdata_q <= regs_q.ep_mode[2];
          A_USB_STAT_CTRL: io_rdata_q <= regs_q.usb_stat_ctrl;
          A_GLOBAL_IRQ_EN: io_rdata_q <= regs_q.global_irq_en;
          A_EP_IRQ_EN: io_rdata_q <= regs_q.ep_irq_en;
          A_TIMER_LOW: io_rdata_q <= timer_count[7:0];
          A_TIMER_HIGH: io_rdata_q <= {4'h0, timer_high_q};
          A_SINK_DATA: io_rdata_q <= regs_q.sink_data;
          A_PROC_STAT_CTRL: io_rdata_q <= regs_q.proc_stat_ctrl;
          default: io_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  reset_vector_a: assert property (@(posedge mclk) !rst_n |=> vector_q == 14'h0000 && psp_q == 8'h00)
    else $error("fetch address or program stack not zero after reset");
  timer_vector_a: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_take && irq_src == IORM_SRC_TMR_1MS |=> vector_q == 14'h0006 && vector_valid_q)
    else $error("1 ms timer vector wrong");
  ep_vector_a: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_take && irq_src == IORM_SRC_EP2 |=> vector_q == 14'h000C)
    else $error("endpoint 2 vector wrong");
  gpio_vector_a: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_take && irq_src == IORM_SRC_GPIO |=> vector_q == 14'h0016 && vector_q >= 14'h0014)
    else $error("GPIO vector wrong");
  index_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    io_req.port_indexed_write_instr && io_req.addr == 8'h00 && io_req.index_x == 8'h26 |=> watchdog_clear_q)
    else $error("indexed write missed its port");
  timer_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_hit_timer_low |=> timer_high_q == $past(timer_count[11:8]) && io_rvalid_q)
    else $error("timer high bits not latched on low read");
  wdt_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    watchdog_clear_q |=> !watchdog_clear_q || $past(wr_any && wr_addr == A_WDT_CLEAR))
    else $error("watchdog clear strobe stuck");
  wo_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    io_req.port_read_instr && io_req.addr inside {8'h04, 8'h26, 8'h38, 8'h09} |=> io_rdata_q == 8'h00)
    else $error("write-only or unassigned port read not zero");
  dsp_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dsp_q == 8'h00 && stack_op.dsp_push && !stack_op.dsp_load |=> dsp_q == 8'hFF)
    else $error("first push from zero did not land at top byte");
  ep_region_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ram_addr == 8'hF0 |-> ram_region == IORM_RGN_EP1)
    else $error("endpoint 1 buffer base wrong");
  cause_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    watchdog_reset_seen |=> regs_q.proc_stat_ctrl[6])
    else $error("watchdog cause not recorded");

  timer_pair_c: cover property (@(posedge mclk) disable iff (!rst_n)
    rd_hit_timer_low ##1 (io_req.port_read_instr && io_req.addr == A_TIMER_HIGH));
  indexed_write_c: cover property (@(posedge mclk) disable iff (!rst_n) io_req.port_indexed_write_instr);
  irq_vector_c: cover property (@(posedge mclk) disable iff (!rst_n) irq_take ##1 vector_valid_q);
endmodule

/* iorm_pkg.sv */
// Purpose: Shared constants and carrier types for the I/O register map and vector block.
// Assumes: One 40 MHz core clock; the processor core issues one I/O operation per cycle.
// Notes: Offsets are I/O port addresses; vectors are program memory word addresses.
package iorm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking and free-running timer.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMER_TICK_NS = 1000;
  localparam int TIMER_DIV = TIMER_TICK_NS / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Program memory map.
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_USB_RESET = 14'h0002;
  localparam logic [13:0] VEC_TMR_128US = 14'h0004;
  localparam logic [13:0] VEC_TMR_1MS = 14'h0006;
  localparam logic [13:0] VEC_EP0 = 14'h0008;
  localparam logic [13:0] VEC_EP1 = 14'h000A;
  localparam logic [13:0] VEC_EP2 = 14'h000C;
  localparam logic [13:0] VEC_CURRENT_SINK = 14'h0014;
  localparam logic [13:0] VEC_GPIO = 14'h0016;
  localparam logic [13:0] APP_CODE_START = 14'h001A;
  localparam logic [13:0] ROM_END_6K = 14'h17FF;
  localparam logic [13:0] ROM_END_8K = 14'h1FDF;

  ////////////////////////////////////////////////////////////////////////////
  // Data RAM map.
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] PSP_RESET = 8'h00;
  localparam logic [7:0] DSP_RESET = 8'h00;
  localparam logic [7:0] EP2_BUF_BASE = 8'hE8;
  localparam logic [7:0] EP1_BUF_BASE = 8'hF0;
  localparam logic [7:0] EP0_BUF_BASE = 8'hF8;

  ////////////////////////////////////////////////////////////////////////////
  // I/O port addresses.
  localparam logic [7:0] A_PORT0_DATA = 8'h00;
  localparam logic [7:0] A_PORT3_DATA = 8'h03;
  localparam logic [7:0] A_PORT0_IRQ_EN = 8'h04;
  localparam logic [7:0] A_PORT3_IRQ_EN = 8'h07;
  localparam logic [7:0] A_PIN_DRIVE_CFG = 8'h08;
  localparam logic [7:0] A_USB_DEV_ADDR = 8'h10;
  localparam logic [7:0] A_EP0_COUNT = 8'h11;
  localparam logic [7:0] A_EP0_MODE = 8'h12;
  localparam logic [7:0] A_EP1_COUNT = 8'h13;
  localparam logic [7:0] A_EP1_MODE = 8'h14;
  localparam logic [7:0] A_EP2_COUNT = 8'h15;
  localparam logic [7:0] A_EP2_MODE = 8'h16;
  localparam logic [7:0] A_USB_STAT_CTRL = 8'h1F;
  localparam logic [7:0] A_GLOBAL_IRQ_EN = 8'h20;
  localparam logic [7:0] A_EP_IRQ_EN = 8'h21;
  localparam logic [7:0] A_TIMER_LOW = 8'h24;
  localparam logic [7:0] A_TIMER_HIGH = 8'h25;
  localparam logic [7:0] A_WDT_CLEAR = 8'h26;
  localparam logic [7:0] A_SINK_DATA = 8'h30;
  localparam logic [7:0] A_SINK_IRQ_EN = 8'h31;
  localparam logic [7:0] A_SINK_IRQ_POL = 8'h32;
  localparam logic [7:0] A_SINK_LEVEL0 = 8'h38;
  localparam logic [7:0] A_SINK_LEVEL7 = 8'h3F;
  localparam logic [7:0] A_PROC_STAT_CTRL = 8'hFF;

  // Processor status and control fields and reset values.
  localparam int PSC_POR_BIT = 4;
  localparam int PSC_USB_RST_BIT = 5;
  localparam int PSC_WDR_BIT = 6;
  localparam logic [7:0] PSC_RESET = 8'h10;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources in vector table order.
  typedef enum logic [3:0] {
    IORM_SRC_USB_RESET = 4'h0,
    IORM_SRC_TMR_128US = 4'h1,
    IORM_SRC_TMR_1MS = 4'h2,
    IORM_SRC_EP0 = 4'h3,
    IORM_SRC_EP1 = 4'h4,
    IORM_SRC_EP2 = 4'h5,
    IORM_SRC_SINK = 4'h6,
    IORM_SRC_GPIO = 4'h7
  } iorm_src_t;

  // Data RAM partition reported for an address.
  typedef enum logic [1:0] {
    IORM_RGN_GENERAL = 2'h0,
    IORM_RGN_EP2 = 2'h1,
    IORM_RGN_EP1 = 2'h2,
    IORM_RGN_EP0 = 2'h3
  } iorm_region_t;

  // One I/O instruction from the core.
  typedef struct packed {
    logic port_read_instr;
    logic port_write_instr;
    logic port_indexed_write_instr;
    logic [7:0] addr;
    logic [7:0] index_x;
    logic [7:0] acc;
  } iorm_io_req_t;

  // Stack pointer operations from the core.
  typedef struct packed {
    logic psp_push;
    logic psp_pop;
    logic dsp_push;
    logic dsp_pop;
    logic dsp_load;
    logic [7:0] dsp_value;
  } iorm_stack_op_t;

  // Register contents handed to the peripheral blocks.
  typedef struct packed {
    logic [3:0][7:0] port_data;
    logic [3:0][7:0] port_irq_en;
    logic [7:0] pin_drive_cfg;
    logic [7:0] usb_dev_addr;
    logic [2:0][7:0] ep_count;
    logic [2:0][7:0] ep_mode;
    logic [7:0] usb_stat_ctrl;
    logic [7:0] global_irq_en;
    logic [7:0] ep_irq_en;
    logic [7:0] sink_data;
    logic [7:0] sink_irq_en;
    logic [7:0] sink_irq_pol;
    logic [7:0][3:0] sink_level;
    logic [7:0] proc_stat_ctrl;
  } iorm_regs_t;

endpackage

/* iorm_data_ram.sv */
// Purpose: The 256-byte data RAM shared by stacks, variables and endpoint buffers.
// Assumes: One access per cycle; write and read share the address.
// Notes: Read data come from a register one cycle after the address.
module iorm_data_ram #(
  parameter int DEPTH = iorm_pkg::RAM_DEPTH
) (
  input wire logic mclk,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  output logic [7:0] rdata
);
  import iorm_pkg::*;

  logic [7:0] mem [DEPTH];

  // Write first, then register the old contents; the core never reads a byte it writes in the same cycle.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

/* iorm_free_timer.sv */
// Purpose: Twelve-bit free-running timer that advances once per microsecond.
// Assumes: mclk at 40 MHz, so the prescaler divides by forty.
// Notes: The count wraps silently; nothing in this block is told about wraps.
module iorm_free_timer #(
  parameter int DIV = iorm_pkg::TIMER_DIV,
  parameter int WIDTH = iorm_pkg::TIMER_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic [WIDTH-1:0] count_q
);
  import iorm_pkg::*;

  logic [7:0] pre_q;

  // Prescaler reaching the last cycle of each microsecond.
  always_ff @(posedge mclk) begin
    if (!rst_n || pre_q == 8'(DIV - 1)) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // Count advances on the prescaler's last cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (pre_q == 8'(DIV - 1)) begin
      count_q <= count_q + 1'b1;
    end
  end
endmodule

/* iorm_core_model.sv */
// Purpose: Behavioural processor core that issues I/O instructions.
// Assumes: One instruction per clock, launched just after a rising edge.
// Notes: Idle cycles lower every strobe and scramble the operands.
module iorm_core_model (
  input wire logic mclk,
  output iorm_pkg::iorm_io_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import iorm_pkg::*;
  initial req = '0;
  // Operands are inverted when idle so a stale address can never pass for a live one.
  task automatic op(input logic [2:0] kind, input logic [7:0] a, x, d);
    @(posedge mclk);
    req <= (kind == 3'b000) ? {3'b000, ~a, ~x, ~d} : {kind, a, x, d};
  endtask
endmodule

/* io_register_map_and_vectors_tb_top.sv */
// Purpose: Self-checking bench for the I/O map, vectors, stacks and RAM partition.
// Assumes: Read answers arrive one cycle after the request.
// Notes: Mode set pulses and the bus reset cause stay low; the timer is modelled by counting edges.
module io_register_map_and_vectors_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iorm_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_take = 1'b0;
  iorm_src_t irq_src = IORM_SRC_USB_RESET;
  logic [13:0] prog_addr = 14'h0000;
  iorm_stack_op_t stack_op = '0;
  logic [7:0] ram_addr = 8'h00;
  logic [7:0] ram_wdata = 8'h00;
  logic ram_we = 1'b0;
  logic wdr_seen = 1'b0;
  logic [11:0] tmr;
  int n_edge = 0;
  iorm_io_req_t io_req;
  iorm_regs_t regs_q;
  iorm_region_t ram_region;
  logic [7:0] io_rdata_q, psp_q, dsp_q, ram_rdata, v;
  logic [13:0] vector_q;
  logic io_rvalid_q, vector_valid_q, prog_addr_ok, watchdog_clear_q;
  int n_mismatch = 0;
  int checked = 0;
  logic [15:0] exp_q[$];
  logic [13:0] vt[8] = '{VEC_USB_RESET, VEC_TMR_128US, VEC_TMR_1MS, VEC_EP0, VEC_EP1, VEC_EP2, VEC_CURRENT_SINK, VEC_GPIO};
  always #12.5 mclk = ~mclk;
  // Edges seen out of reset; the timer advances once every forty of them.
  always @(posedge mclk) n_edge <= rst_n ? n_edge + 1 : 0;
  iorm_core_model u_core (.mclk(mclk), .req(io_req));
  iorm_core_map u_dut (.mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_rdata_q(io_rdata_q),
    .io_rvalid_q(io_rvalid_q), .irq_take(irq_take), .irq_src(irq_src), .vector_q(vector_q),
    .vector_valid_q(vector_valid_q), .prog_addr(prog_addr), .prog_addr_ok(prog_addr_ok),
    .stack_op(stack_op), .psp_q(psp_q), .dsp_q(dsp_q), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_rdata(ram_rdata), .ram_region(ram_region), .usb_bus_reset_seen(1'b0),
    .watchdog_reset_seen(wdr_seen), .ep_mode_hw_set(16'h0000), .watchdog_clear_q(watchdog_clear_q),
    .regs_q(regs_q));
  ////////////////////////////////////////////////////////////////////////////
  // Every comparison goes through here so the counts stay honest.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    u_core.op(3'b100, a, 8'h5A, 8'hC3);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Oldest expectation is matched to each read answer as it appears.
  always @(posedge mclk) begin
    if (rst_n && io_rvalid_q === 1'b1)
      chk({8'h00, io_rdata_q}, exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    v = 8'($urandom(40141));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk(vector_q, VEC_RESET);
    chk({psp_q, dsp_q}, {PSP_RESET, DSP_RESET});
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) irq_take <= 1'b1;
      irq_src <= iorm_src_t'(i);
      @(posedge mclk) irq_take <= 1'b0;
      #1 chk({vector_valid_q, vector_q}, {1'b1, vt[i]});
    end
    @(posedge mclk) stack_op <= {5'b10100, 8'h00};
    @(posedge mclk) stack_op <= '0;
    #1 chk({psp_q, dsp_q}, 16'h01FF);
    @(posedge mclk) stack_op <= {5'b00001, 8'hE8};
    @(posedge mclk) stack_op <= {5'b00100, 8'h00};
    @(posedge mclk) stack_op <= '0;
    #1 chk(dsp_q, 8'hE7);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) ram_addr <= 8'({8'hE7, 8'hE8, 8'hF0, 8'hF8} >> (24 - 8 * i));
      prog_addr <= ROM_END_8K + 14'(i[0]);
      #1 chk({prog_addr_ok, 6'h00, ram_region}, {~i[0], 6'h00, 2'(i)});
    end
    v = 8'($urandom);
    // Top RAM byte written and read back; application code start must lie in program memory.
    @(posedge mclk) {ram_we, ram_wdata, ram_addr} <= {1'b1, v, 8'hFF};
    prog_addr <= APP_CODE_START;
    #1 chk(prog_addr_ok, 1'b1);
    @(posedge mclk) ram_we <= 1'b0;
    @(posedge mclk) #1 chk(ram_rdata, v);
    rd(A_PROC_STAT_CTRL, PSC_RESET);
    // A watchdog cause in the cycle of a clearing write must still be recorded.
    u_core.op(3'b010, A_PROC_STAT_CTRL, 8'h00, 8'h00);
    wdr_seen <= 1'b1;
    rd(A_PROC_STAT_CTRL, 8'h40);
    wdr_seen <= 1'b0;
    u_core.op(3'b010, A_USB_DEV_ADDR, 8'h77, v);
    rd(A_USB_DEV_ADDR, v);
    u_core.op(3'b001, 8'h0F, 8'h01, ~v);
    rd(A_USB_DEV_ADDR, ~v);
    u_core.op(3'b001, 8'h00, A_GLOBAL_IRQ_EN, v);
    rd(A_GLOBAL_IRQ_EN, v);
    u_core.op(3'b010, A_PORT0_IRQ_EN, 8'h00, 8'hFF);
    rd(A_PORT0_IRQ_EN, 8'h00);
    u_core.op(3'b010, 8'h09, 8'h00, v);
    rd(8'h09, 8'h00);
    for (int i = 0; i < 2; i++) begin
      u_core.op(3'b010, i ? A_EP1_MODE : A_EP0_MODE, 8'h00, 8'h0F);
      u_core.op(3'b010, i ? A_EP1_MODE : A_EP0_MODE, 8'h00, 8'hF0);
      rd(i ? A_EP1_MODE : A_EP0_MODE, i ? 8'h00 : 8'hF0);
    end
    u_core.op(3'b010, A_SINK_LEVEL7, 8'h00, 8'hAB);
    u_core.op(3'b001, 8'h00, A_WDT_CLEAR, v);
    rd(A_SINK_LEVEL7, 8'h00);
    #1 chk({watchdog_clear_q, regs_q.sink_level[7]}, 5'h1B);
    u_core.op(3'b000, 8'h00, 8'h00, 8'h00);
    #1 chk(watchdog_clear_q, 1'b0);
    // Run long enough for the upper timer bits to move, then read the pair back to back.
    repeat (10300) @(posedge mclk);
    #1 tmr = 12'((n_edge + 1) / 40);
    rd(A_TIMER_LOW, tmr[7:0]);
    rd(A_TIMER_HIGH, {4'h0, tmr[11:8]});
    u_core.op(3'b000, 8'h00, 8'h00, 8'h00);
    repeat (4) @(posedge mclk);
    chk(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule
